//--- src_defines.svh
// constants for the set/reset counter channel
`ifndef SRC_DEFINES_SVH
`define SRC_DEFINES_SVH

// register byte offsets
`define SRC_OFS_CTRL 12'h000
`define SRC_OFS_START 12'h004
`define SRC_OFS_STATUS 12'h008
`define SRC_OFS_INST 12'h00c
`define SRC_OFS_AVG 12'h010
// program windows of 1024 bytes, one token per word
`define SRC_OFS_SET_PROG 12'h400
`define SRC_OFS_RST_PROG 12'h800

// field positions
`define SRC_CTRL_QUAL_LSB 0
`define SRC_STAT_SET_STATE 0
`define SRC_STAT_SET_RES 1
`define SRC_STAT_RST_RES 2
`define SRC_STAT_SET_MISS 3
`define SRC_STAT_RST_MISS 4
`define SRC_STAT_BUSY 5

// token layout: [7:6] opcode, [5] inverted, [4:0] input line
`define SRC_TOK_OP_MSB 7
`define SRC_TOK_OP_LSB 6
`define SRC_TOK_INV 5
`define SRC_TOK_LINE_MSB 4
`define SRC_TOK_OP_END 2'h0
`define SRC_TOK_OP_PUSH 2'h1
`define SRC_TOK_OP_AND 2'h2
`define SRC_TOK_OP_OR 2'h3

// sizes and reset values
`define SRC_PROG_LEN 80
`define SRC_RST_QUAL 2'h0
`define SRC_RST_START 32'h0000_0000
`define SRC_DFLT_SET 1'b1
`define SRC_DFLT_RST 1'b0

`endif

//--- src_pkg.sv
// types of the set/reset counter channel
`default_nettype none
package src_pkg;
   // qualification code: neither, set only, reset only, both
   typedef enum logic [1:0] {
      SRC_QUAL_N = 2'b00,
      SRC_QUAL_S = 2'b01,
      SRC_QUAL_R = 2'b10,
      SRC_QUAL_Y = 2'b11
   } src_qual_t;
   // pattern evaluation sequencer
   typedef enum logic [1:0] {
      SRC_EV_IDLE = 2'b00,
      SRC_EV_SET = 2'b01,
      SRC_EV_RST = 2'b10,
      SRC_EV_APPLY = 2'b11
   } src_ev_t;
endpackage : src_pkg
`default_nettype wire

//--- src_counter_channel.sv
// set/reset counter channel with wishbone registers
//
// Contract
// [RULE_01] patterns are and/or expressions over input lines, nesting allowed
// [RULE_02] an inverted term is true when its line is inactive
// [RULE_03] each pattern holds at most eighty stored symbols
// [RULE_04] both patterns sampled each second; both true acts as reset
// [RULE_05] evaluation is level based; set returns once reset clears
// [RULE_06] an empty set pattern is always true
// [RULE_07] an empty reset pattern is always false
// [RULE_08] qualified pattern acts only if true at every interval sample
// [RULE_09] qualification test finishes before the interval-end add
// [RULE_10] qualification code: set, reset, both or neither; neither default
// [RULE_11] both qualified: both held whole interval resets at interval end
// [RULE_12] entering reset loads the instantaneous value with start value
// [RULE_13] at interval end in set state add equation, store base average
// [RULE_14] value stays constant between interval ends
// [RULE_15] reset qualified: set any sample, reset only at interval end
// [RULE_16] reset qualified: full reset beats a set true at last sample
// [RULE_17] after configuration the flip-flop starts in reset
// [RULE_18] in reset the value holds the start value, no accumulation
// [RULE_19] set qualified: reset any sample, set only at end, reset wins
// [RULE_20] sample and interval-end strobes; sticky miss flags per pattern
`default_nettype none
`include "src_defines.svh"

module src_counter_channel
   import src_pkg::*;
#(
   parameter int N_LINES = 32,
   parameter int DW = 32,
   parameter int PROG_LEN = `SRC_PROG_LEN,
   parameter int STK_D = 16
) (
   // clock, reset, enable
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   // digital input lines and pacing strobes
   input wire logic [N_LINES-1:0] in_lines,
   input wire logic sample_stb,
   input wire logic interval_end,
   // equation result for this interval
   input wire logic signed [DW-1:0] eq_result,
   // channel results
   output logic signed [DW-1:0] inst_value,
   output logic signed [DW-1:0] base_avg,
   output logic base_avg_valid,
   output logic state_set,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);

   localparam int PCW = $clog2(PROG_LEN);
   localparam logic [PCW-1:0] PC_LAST = PCW'(PROG_LEN - 1);

   ////////////////////////////////////////////////////////////////////
   // state
   src_qual_t qual;
   logic signed [DW-1:0] start_val;
   logic [7:0] set_prog [PROG_LEN];
   logic [7:0] rst_prog [PROG_LEN];
   src_ev_t ev;
   logic [PCW-1:0] pc;
   logic [STK_D-1:0] stk;
   logic nonempty;
   logic [N_LINES-1:0] lines_q;
   logic is_smp;
   logic is_end;
   logic set_res;
   logic rst_res;
   logic set_miss;
   logic rst_miss;

   ////////////////////////////////////////////////////////////////////
   // wishbone decode
   logic wb_req;
   logic wr_req;
   logic prog_hit;
   logic win_set;
   logic win_rst;
   logic [PCW-1:0] prog_idx;
   logic idx_ok;
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_req = wb_req & wb_we_i;
   // window index in bits 8..2, upper half of each window unmapped
   assign prog_idx = wb_adr_i[PCW+1:2];
   assign idx_ok = !wb_adr_i[9] && (32'(wb_adr_i[8:2]) < PROG_LEN);
   assign win_set = ({wb_adr_i[11:10], 10'h000} == `SRC_OFS_SET_PROG);
   assign win_rst = ({wb_adr_i[11:10], 10'h000} == `SRC_OFS_RST_PROG);
   assign prog_hit = idx_ok && (win_set || win_rst); // [RULE_03]

   // one ack per request, registered one cycle after the strobe
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
      end else if (ce) begin
         wb_ack_o <= wb_req;
      end
   end

   // control registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         qual <= src_qual_t'(`SRC_RST_QUAL); // [RULE_10]
         start_val <= `SRC_RST_START;
      end else if (ce && wr_req) begin
         if (wb_adr_i == `SRC_OFS_CTRL && wb_sel_i[0]) begin
            qual <= src_qual_t'(wb_dat_i[`SRC_CTRL_QUAL_LSB +: 2]);
         end
         if (wb_adr_i == `SRC_OFS_START && wb_sel_i == 4'hf) begin
            start_val <= DW'(wb_dat_i);
         end
      end
   end

   // pattern programs, at most eighty symbols each
   always_ff @(posedge core_clk) begin
      if (ce && wr_req && prog_hit && wb_sel_i[0]) begin // [RULE_03]
         if (win_set) begin
            set_prog[prog_idx] <= wb_dat_i[7:0];
         end else begin
            rst_prog[prog_idx] <= wb_dat_i[7:0];
         end
      end
   end

   // read data, unmapped reads give zero
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (ce) begin
         wb_dat_o <= 32'h0000_0000;
         if (wb_req && !wb_we_i) begin
            if (prog_hit) begin
               if (win_set) begin
                  wb_dat_o <= {24'h00_0000, set_prog[prog_idx]};
               end else begin
                  wb_dat_o <= {24'h00_0000, rst_prog[prog_idx]};
               end
            end else begin
               case (wb_adr_i)
                  `SRC_OFS_CTRL: wb_dat_o <= {30'h0, qual};
                  `SRC_OFS_START: wb_dat_o <= 32'(start_val);
                  `SRC_OFS_STATUS: begin
                     wb_dat_o <= {26'h0, ev != SRC_EV_IDLE, rst_miss,
                                  set_miss, rst_res, set_res, state_set};
                  end
                  `SRC_OFS_INST: wb_dat_o <= 32'(inst_value);
                  `SRC_OFS_AVG: wb_dat_o <= 32'(base_avg);
                  default: wb_dat_o <= 32'h0000_0000;
               endcase
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // postfix expression step: push line, and, or, end
   logic [7:0] tok;
   logic [1:0] op;
   logic line_bit;
   logic dflt;
   logic [STK_D-1:0] next_stk;
   logic done;
   logic fin_res;
   assign tok = (ev == SRC_EV_SET) ? set_prog[pc] : rst_prog[pc];
   assign op = tok[`SRC_TOK_OP_MSB:`SRC_TOK_OP_LSB];
   // inverted term true on an inactive line
   assign line_bit = lines_q[tok[`SRC_TOK_LINE_MSB:0]]
                     ^ tok[`SRC_TOK_INV]; // [RULE_02]
   assign dflt = (ev == SRC_EV_SET) ? `SRC_DFLT_SET // [RULE_06]
                                    : `SRC_DFLT_RST; // [RULE_07]

   // stack update, top of stack in bit 0
   always_comb begin
      next_stk = stk;
      case (op)
         `SRC_TOK_OP_PUSH: next_stk = {stk[STK_D-2:0], line_bit};
         `SRC_TOK_OP_AND: begin
            next_stk = {1'b0, stk[STK_D-1:2], stk[1] & stk[0]}; // [RULE_01]
         end
         `SRC_TOK_OP_OR: begin
            next_stk = {1'b0, stk[STK_D-1:2], stk[1] | stk[0]}; // [RULE_01]
         end
         default: next_stk = stk;
      endcase
   end

   assign done = (op == `SRC_TOK_OP_END) || (pc == PC_LAST);
   // empty program falls back to its default value
   assign fin_res = (op == `SRC_TOK_OP_END)
                    ? (nonempty ? stk[0] : dflt) : next_stk[0];

   // sequencer: latch lines, run set then reset, then apply
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ev <= SRC_EV_IDLE;
         pc <= '0;
         stk <= '0;
         nonempty <= 1'b0;
         lines_q <= '0;
         is_smp <= 1'b0;
         is_end <= 1'b0;
         set_res <= 1'b0;
         rst_res <= 1'b0;
      end else if (ce) begin
         case (ev)
            SRC_EV_IDLE: begin
               if (sample_stb || interval_end) begin // [RULE_20]
                  lines_q <= in_lines; // [RULE_05]
                  is_smp <= sample_stb;
                  is_end <= interval_end;
                  pc <= '0;
                  stk <= '0;
                  nonempty <= 1'b0;
                  ev <= SRC_EV_SET;
               end
            end
            SRC_EV_SET, SRC_EV_RST: begin
               if (done) begin
                  if (ev == SRC_EV_SET) begin
                     set_res <= fin_res;
                     ev <= SRC_EV_RST;
                  end else begin
                     rst_res <= fin_res;
                     ev <= SRC_EV_APPLY;
                  end
                  pc <= '0;
                  stk <= '0;
                  nonempty <= 1'b0;
               end else begin
                  stk <= next_stk;
                  pc <= pc + 1'b1;
                  nonempty <= 1'b1;
               end
            end
            SRC_EV_APPLY: ev <= SRC_EV_IDLE;
            default: ev <= SRC_EV_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // flip-flop decision
   logic qual_set;
   logic qual_rst;
   logic full_set;
   logic full_rst;
   logic eff_set;
   logic eff_rst;
   logic next_state_set;
   logic apply;
   logic signed [DW-1:0] sum;
   assign apply = (ev == SRC_EV_APPLY);
   assign qual_set = (qual == SRC_QUAL_S) || (qual == SRC_QUAL_Y);
   assign qual_rst = (qual == SRC_QUAL_R) || (qual == SRC_QUAL_Y);
   // true at every sample of the interval, this one included
   assign full_set = !set_miss && (set_res || !is_smp); // [RULE_08]
   assign full_rst = !rst_miss && (rst_res || !is_smp); // [RULE_08]
   // qualified patterns act only at the interval end
   assign eff_set = qual_set ? (is_end && full_set) // [RULE_19]
                             : (is_smp && set_res); // [RULE_15]
   assign eff_rst = qual_rst ? (is_end && full_rst) // [RULE_15]
                             : (is_smp && rst_res); // [RULE_19]
   // reset has priority over set in every mode
   assign next_state_set = eff_rst ? 1'b0 // [RULE_04] [RULE_11] [RULE_16]
                         : (eff_set ? 1'b1 : state_set); // [RULE_05]
   assign sum = inst_value + eq_result;

   // set/reset flip-flop, starts in reset
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_set <= 1'b0; // [RULE_17]
      end else if (ce && apply) begin
         state_set <= next_state_set;
      end
   end

   // per-pattern miss flags, cleared when a new interval begins
   always_ff @(posedge core_clk) begin
      if (rst) begin
         set_miss <= 1'b0;
         rst_miss <= 1'b0;
      end else if (ce && apply) begin
         if (is_end) begin
            set_miss <= 1'b0; // [RULE_20]
            rst_miss <= 1'b0;
         end else if (is_smp) begin
            set_miss <= set_miss | !set_res; // [RULE_20]
            rst_miss <= rst_miss | !rst_res;
         end
      end
   end

   // counter value and stored base average
   always_ff @(posedge core_clk) begin
      if (rst) begin
         inst_value <= `SRC_RST_START;
         base_avg <= `SRC_RST_START;
         base_avg_valid <= 1'b0;
      end else if (ce) begin
         base_avg_valid <= 1'b0;
         if (apply && is_end) begin
            // decision made above before any add
            if (next_state_set) begin // [RULE_09]
               inst_value <= sum; // [RULE_13]
               base_avg <= sum;
            end else begin
               inst_value <= start_val; // [RULE_18]
               base_avg <= start_val;
            end
            base_avg_valid <= 1'b1;
         end else if (apply && !next_state_set) begin
            inst_value <= start_val; // [RULE_12]
         end else if (!state_set) begin
            inst_value <= start_val; // [RULE_18]
         end
         // otherwise the value stays put between interval ends [RULE_14]
      end
   end

endmodule : src_counter_channel
`default_nettype wire

//--- src_chk.sv
// port checks of the counter channel
`default_nettype none
module src_chk #(
   parameter int DW = 32
) (
   // clock, reset, enable
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   // strobes and results
   input wire logic sample_stb,
   input wire logic interval_end,
   input wire logic signed [DW-1:0] eq_result,
   input wire logic signed [DW-1:0] inst_value,
   input wire logic signed [DW-1:0] base_avg,
   input wire logic base_avg_valid,
   input wire logic state_set,
   // wishbone
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   logic [7:0] gap;
   ////////////////////////////////////////
   // cycles since the last strobe
   always_ff @(posedge core_clk) begin
      if (rst || sample_stb || interval_end)
         gap <= 8'h00;
      else if (gap != 8'hff)
         gap <= gap + 8'h01;
   end
   ////////////////////////////////////////
   sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o && ce; endsequence
   sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
   property p_ack; s_take |=> s_ack; endproperty
   property p_dat; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
   property p_pace; $changed(state_set) |-> gap inside {[3:165]}; endproperty
   property p_apace; base_avg_valid |-> gap inside {[3:165]}; endproperty
   property p_pulse; base_avg_valid |=> !base_avg_valid; endproperty
   property p_same; base_avg_valid |-> base_avg == inst_value; endproperty
   property p_add; base_avg_valid && state_set |->
      base_avg == $past(inst_value) + $past(eq_result); endproperty
   property p_hold; state_set && $past(state_set) && !base_avg_valid
      |-> $stable(inst_value); endproperty
   property p_keep; !base_avg_valid && !$past(rst) |-> $stable(base_avg);
   endproperty
   property p_init; $fell(rst) |-> !state_set; endproperty
   a_ack: assert property (p_ack) else $error("ack timing");
   a_dat: assert property (p_dat) else $error("data idle");
   a_pace: assert property (p_pace) else $error("state pace");
   a_apace: assert property (p_apace) else $error("avg pace");
   a_pulse: assert property (p_pulse) else $error("valid len");
   a_same: assert property (p_same) else $error("avg inst");
   a_add: assert property (p_add) else $error("avg sum");
   a_hold: assert property (p_hold) else $error("inst moved");
   a_keep: assert property (p_keep) else $error("avg moved");
   a_init: assert property (p_init) else $error("init state");
endmodule : src_chk
bind src_counter_channel src_chk #(.DW(DW)) u_chk (.core_clk(core_clk),
   .rst(rst), .ce(ce), .sample_stb(sample_stb), .interval_end(interval_end),
   .eq_result(eq_result), .inst_value(inst_value), .base_avg(base_avg),
   .base_avg_valid(base_avg_valid), .state_set(state_set),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o));
`default_nettype wire

//--- src_line_model.sv
// input line driver and average record store
`default_nettype none
module src_line_model (
   // clock and wanted line levels
   input wire logic core_clk,
   input wire logic [31:0] want,
   output logic [31:0] lines,
   // stored average records
   input wire logic avg_vld,
   input wire logic signed [31:0] avg,
   output int n_rec,
   output logic signed [31:0] last_avg
);
   timeunit 1ns;
   timeprecision 100ps;
   initial lines = 32'h0;
   initial n_rec = 0;
   // lines follow one cycle later; written averages are counted, the last one kept
   always @(posedge core_clk) begin
      lines <= want;
      if (avg_vld === 1'b1) begin
         n_rec <= n_rec + 1;
         last_avg <= avg;
      end
   end
endmodule : src_line_model
`default_nettype wire

//--- src_counter_channel_tb.sv
// self-checking bench of the counter channel
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
   $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module src_counter_channel_tb;
   import src_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk = 0, rst = 1, sample_stb = 0, interval_end = 0;
   logic req = 0, we = 0, ack, vld, st;
   logic [11:0] adr = 0;
   logic [31:0] wdat = 0, want = 0, lines, rdat, q, la;
   logic signed [31:0] eq = 0, inst, avg;
   logic [7:0] sp [6] = '{8'h40, 8'h61, 8'hc0, 8'h42, 8'h80, 8'h00};
   logic [7:0] rp [4] = '{8'h43, 8'h64, 8'h80, 8'h00};
   int bad_count = 0, n_tests = 0, nrec, n_av = 0;
   int m_st = 0, m_inst = 0, m_start = 0, m_q = 0, ms = 0, mr = 0, prog = 0;
   ////////////////////////////////////////
   always #12.5 core_clk = ~core_clk;
   src_counter_channel DUT (.core_clk(core_clk), .rst(rst), .ce(1'b1),
      .in_lines(lines), .sample_stb(sample_stb),
      .interval_end(interval_end), .eq_result(eq), .inst_value(inst),
      .base_avg(avg), .base_avg_valid(vld), .state_set(st),
      .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
   src_line_model u_far (.core_clk(core_clk), .want(want), .lines(lines),
      .avg_vld(vld), .avg(avg), .n_rec(nrec), .last_avg(la));
   ////////////////////////////////////////
   // report and end the run
   task automatic test_done(input bit hang);
      if (hang)
         bad_count++;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : test_done
   // one classic wishbone cycle
   task automatic wb(input logic [11:0] a, input logic w, input int d);
      int i;
      @(posedge core_clk);
      req <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= 32'(d);
      // ack and read data are taken at the same rising edge
      for (i = 0; i < 20 && ack !== 1'b1; i++)
         @(posedge core_clk);
      if (i == 20)
         test_done(1);
      q = rdat;
      req <= 1'b0;
   endtask : wb
   // one sample, optionally the interval end, against the model
   task automatic strobe(input bit e, input bit hold);
      logic [31:0] l;
      int s, r, ev;
      l = hold ? want : $urandom;
      ev = int'($urandom_range(0, 30)) - 15;
      @(posedge core_clk);
      want <= l;
      eq <= 32'(ev);
      repeat (2) @(posedge core_clk);
      sample_stb <= 1'b1;
      interval_end <= e;
      @(posedge core_clk);
      sample_stb <= 1'b0;
      interval_end <= 1'b0;
      s = prog ? int'((l[0] | ~l[1]) & l[2]) : 1;
      r = prog ? int'(l[3] & ~l[4]) : 0;
      ms = ms | !s;
      mr = mr | !r;
      s = m_q[0] ? (e && !ms) : s;
      r = m_q[1] ? (e && !mr) : r;
      // a start written while in reset is followed at once
      if (!m_st)
         m_inst = m_start;
      m_st = r ? 0 : (s ? 1 : m_st);
      if (!m_st)
         m_inst = m_start;
      if (e) begin
         m_inst = m_inst + (m_st ? ev : 0);
         ms = 0;
         mr = 0;
         n_av++;
      end
      repeat (30) @(posedge core_clk);
      `CHK(st, m_st[0])
      `CHK(inst, 32'(m_inst))
      `CHK(nrec, n_av)
      if (e)
         `CHK(la, 32'(m_inst))
   endtask : strobe
   ////////////////////////////////////////
   // main sequence
   initial begin
      void'($urandom(32'h7b1d6fec));
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      wb(12'h000, 0, 0);
      `CHK(q, 32'h0)
      wb(12'h0f0, 1, 7);
      wb(12'h0f0, 0, 0);
      `CHK(q, 32'h0)
      `CHK(st, 1'b0)
      wb(12'h400, 1, 0);
      wb(12'h800, 1, 0);
      // last token slot kept, the one past it unmapped
      wb(12'h53c, 1, 32'ha5);
      wb(12'h53c, 0, 0);
      `CHK(q, 32'h0000_00a5)
      wb(12'h540, 1, 32'h5a);
      wb(12'h540, 0, 0);
      `CHK(q, 32'h0)
      for (int p = 0; p < 2; p++) begin
         for (int c = 0; c < 4; c++) begin
            m_start = $urandom_range(0, 99);
            wb(12'h004, 1, m_start);
            m_q = c;
            wb(12'h000, 1, c);
            wb(12'h000, 0, 0);
            `CHK(q, 32'(c))
            for (int k = 0; k < 4; k++) begin
               automatic bit h = 1'($urandom_range(0, 1));
               for (int j = 0; j < 3; j++)
                  strobe(j == 2, h && j > 0);
            end
         end
         prog = 1;
         foreach (sp[i])
            wb(12'h400 + 12'(4 * i), 1, sp[i]);
         foreach (rp[i])
            wb(12'h800 + 12'(4 * i), 1, rp[i]);
      end
      test_done(0);
   end
endmodule : src_counter_channel_tb
`default_nettype wire
